// file: src/iec_counter.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module iec_counter (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire iec_pkg::iec_enc_t enc,
   input  wire logic              hw_hold,
   input  wire logic              hw_reset,
   input  wire logic              module_stop,
   input  wire logic              scan_tick,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hsel,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [7:0]             status
);
   import iec_pkg::*;

   typedef struct packed {
      iec_enc_t    s1;
      iec_enc_t    s2;
      logic        a_d;
      logic        b_d;
      logic        n_d;
      logic [31:0] ctrl;
      logic [2:0]  sw;
      logic [31:0] load;
      logic [31:0] cnt;
      logic        frozen;
      logic        dir;
      logic        home;
      logic        sync;
      logic        ovf;
      logic        unf;
      logic        wire_err;
      logic        hold_d;
      logic        rst_d;
      logic        stop_d;
      iec_bus_t    bus;
      logic [7:0]  wofs;
      logic [31:0] rdata;
   } iec_state_t;

   iec_state_t r;
   iec_state_t next_r;

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers
   logic        wide;
   logic        main_down;
   logic        level_rst;
   iec_mode_t   mode;
   iec_rsrc_t   rsrc;
   logic [31:0] vmax;
   logic [31:0] vmin;
   logic [31:0] rval;
   logic        hold_in;
   logic        rst_in;
   logic        up_step;
   logic        dn_step;
   logic        do_reset;
   logic        do_load;
   logic        in_range;
   logic [31:0] sext;
   logic        bus_take;

   always_comb begin
      wide      = r.ctrl[IEC_CTRL_WIDE];
      mode      = iec_mode_t'(r.ctrl[IEC_CTRL_MODE +: 2]);
      main_down = r.ctrl[IEC_CTRL_DOWN];
      level_rst = r.ctrl[IEC_CTRL_LEVEL];
      rsrc      = iec_rsrc_t'(r.ctrl[IEC_CTRL_RSRC +: 2]);
      vmax      = wide ? IEC_MAX32 : IEC_MAX16;
      vmin      = wide ? IEC_MIN32 : IEC_MIN16;
      hold_in   = hw_hold | r.sw[IEC_SW_HOLD];
      rst_in    = hw_reset | r.sw[IEC_SW_RESET]
                | (r.ctrl[IEC_CTRL_IDXEN] & r.s2.n & ~r.n_d);
      // Step on any A edge; direction from B level (x2-style decode)
      up_step   = (r.s2.a & ~r.a_d & ~r.s2.b)
                | (~r.s2.a & r.a_d & r.s2.b);
      dn_step   = (r.s2.a & ~r.a_d & r.s2.b)
                | (~r.s2.a & r.a_d & ~r.s2.b);
      case (rsrc)
         IEC_RV_MIN:  rval = vmin;
         IEC_RV_MAX:  rval = (mode == IEC_CONT) ? IEC_ZERO : vmax;
         IEC_RV_LOAD: rval = r.load;
         default:     rval = IEC_ZERO;
      endcase
      if (level_rst) begin
         // Fire on the release of hold while reset is still up or drops now
         do_reset = (rst_in & ~hold_in & ~r.rst_d)
                  | (~hold_in & r.hold_d & r.rst_d);
      end else begin
         do_reset = rst_in & ~r.rst_d;
      end
      do_load  = r.sw[IEC_SW_LOAD];
      sext     = {{16{r.cnt[15]}}, r.cnt[15:0]};
      in_range = wide || (r.cnt == sext);
      bus_take = hsel & hready & htrans[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r = r;
      next_r.s1  = enc;
      next_r.s2  = r.s1;
      next_r.a_d = r.s2.a;
      next_r.b_d = r.s2.b;
      next_r.n_d = r.s2.n;
      next_r.hold_d = hold_in;
      next_r.rst_d  = rst_in;
      next_r.stop_d = module_stop;
      // Scan-long flags drop at each scan tick
      if (scan_tick) begin
         next_r.ovf = 1'b0;
         next_r.unf = 1'b0;
      end
      next_r.wire_err = r.ctrl[IEC_CTRL_QUAD]
         & ((r.s2.a == r.s2.a_n) | (r.s2.b == r.s2.b_n)
            | (r.s2.n == r.s2.n_n));

      if (do_reset) begin
         next_r.cnt    = rval;
         next_r.frozen = 1'b0;
         next_r.home   = 1'b1;
         next_r.sync   = 1'b1;
      end else if (do_load) begin
         next_r.cnt    = r.load;
         next_r.frozen = 1'b0;
         next_r.home   = 1'b0;
      end else if (~hold_in & ~r.frozen & (up_step | dn_step)) begin
         next_r.home = 1'b0;
         next_r.dir  = dn_step;
         if (up_step) begin
            if (r.cnt == vmax || (!wide && r.cnt == IEC_MAX32)) begin
               next_r.cnt = vmin;
               if (in_range && (mode == IEC_CONT || !main_down)) begin
                  next_r.ovf = 1'b1;
                  next_r.frozen = (mode == IEC_SINGLE);
               end
            end else begin
               next_r.cnt = r.cnt + 32'h0000_0001;
            end
         end else begin
            if (r.cnt == vmin) begin
               next_r.cnt = vmax;
               if (mode == IEC_CONT || main_down) begin
                  next_r.unf = 1'b1;
                  next_r.frozen = (mode == IEC_SINGLE);
               end
            end else begin
               next_r.cnt = r.cnt - 32'h0000_0001;
            end
         end
      end
      if (!wide && in_range) begin
         next_r.cnt = {{16{next_r.cnt[15]}}, next_r.cnt[15:0]};
      end

      // Software controls are one-shot except hold
      next_r.sw[IEC_SW_RESET] = 1'b0;
      next_r.sw[IEC_SW_LOAD]  = 1'b0;

      // Bus slave: writes land in the data phase
      next_r.bus = IEC_BUS_IDLE;
      case (r.bus)
         IEC_BUS_WRITE: begin
            case (r.wofs)
               IEC_OFS_CTRL:  next_r.ctrl = hwdata;
               IEC_OFS_SWCTL: next_r.sw   = hwdata[2:0];
               IEC_OFS_LOAD:  next_r.load = hwdata;
               default: ;
            endcase
         end
         default: ;
      endcase
      if (bus_take && hwrite) begin
         next_r.bus  = IEC_BUS_WRITE;
         next_r.wofs = haddr[7:0];
      end else if (bus_take) begin
         case (haddr[7:0])
            IEC_OFS_CTRL:   next_r.rdata = r.ctrl;
            IEC_OFS_SWCTL:  next_r.rdata = {29'h0000_0000, r.sw};
            IEC_OFS_LOAD:   next_r.rdata = r.load;
            IEC_OFS_COUNT:  next_r.rdata = r.cnt;
            IEC_OFS_STATUS: next_r.rdata = {24'h00_0000, status};
            default:        next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Module stop: dir, home, ovf, unf and software controls cleared; sync and count kept
      if (module_stop & ~r.stop_d) begin
         next_r.sw   = 3'b000;
         next_r.dir  = 1'b0;
         next_r.home = 1'b0;
         next_r.ovf  = 1'b0;
         next_r.unf  = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r      <= '0;
         r.ctrl <= IEC_CTRL_RST;
         r.bus  <= IEC_BUS_IDLE;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic [7:0] status_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= 8'h00;
      end else begin
         status_q <= {next_r.wire_err, 2'b00, next_r.unf, next_r.ovf,
                      next_r.sync, next_r.home, next_r.dir};
      end
   end
   assign status    = status_q;
   assign hrdata    = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_up_wrap;
      r.ovf && !$past(r.ovf);
   endsequence

   chk_sync_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(r.sync) |-> r.sync)
      else $error("sync bit dropped");
   chk_ovf_one_scan: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.ovf && scan_tick && !next_r.ovf) |=> !r.ovf)
      else $error("overflow outlived its scan");
   chk_ovf_wraps: assert property (@(posedge mclk) disable iff (!rst_n)
      s_up_wrap |-> (r.cnt == vmin))
      else $error("overflow without wrap to minimum");
   chk_unf_wraps: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(r.unf) |-> (r.cnt == vmax))
      else $error("underflow without wrap to maximum");
   chk_dir_down: assert property (@(posedge mclk) disable iff (!rst_n)
      (dn_step && !hold_in && !r.frozen && !do_reset && !do_load
       && !(module_stop && !r.stop_d)) |=> r.dir)
      else $error("direction not set on down step");
   chk_reset_home: assert property (@(posedge mclk) disable iff (!rst_n)
      (do_reset && !(module_stop && !r.stop_d)) |=> (r.home && r.cnt[15:0]
      == $past(rval[15:0])))
      else $error("reset did not home the counter");
   chk_single_freeze: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.frozen && !do_reset && !do_load) |=> $stable(r.cnt))
      else $error("frozen counter moved");
   chk_stop_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      (module_stop && !r.stop_d) |=> (r.sw == 3'b000 && !r.ovf))
      else $error("stop did not clear");
   chk_held_count: assert property (@(posedge mclk) disable iff (!rst_n)
      (hold_in && !do_reset && !do_load) |=> $stable(r.cnt))
      else $error("count moved under hold");

   ////////////////////////////////////////////////////////////////////////////
   // More checks; the free condition keeps stop, hold and freeze out of the step ones
   sequence s_free_step;
      !hold_in && !r.frozen && !do_reset && !do_load
         && !(module_stop && !r.stop_d);
   endsequence

   sequence s_dn_at_min;
      dn_step && (r.cnt == vmin);
   endsequence

   sequence s_stop_edge;
      module_stop && !r.stop_d;
   endsequence

   chk_up_counts: assert property (@(posedge mclk) disable iff (!rst_n)
      (up_step && wide && r.cnt != vmax) ##0 s_free_step
      |=> (!r.dir && r.cnt == $past(r.cnt) + 32'h0000_0001))
      else $error("up step did not add one");
   chk_unf_one_scan: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.unf && scan_tick && !dn_step) |=> !r.unf)
      else $error("underflow outlived its scan");
   chk_edge_rst_wins: assert property (@(posedge mclk) disable iff (!rst_n)
      (!level_rst && hold_in && rst_in && !r.rst_d
       && !(module_stop && !r.stop_d)) |=> r.home)
      else $error("edge reset lost against hold");
   chk_level_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (level_rst && hold_in && !do_load) |=> $stable(r.cnt))
      else $error("level reset fired under hold");
   chk_stop_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
      s_stop_edge ##0 r.sync
      |=> (r.sync && !r.home && !r.unf && !r.dir))
      else $error("stop cleared sync or kept flags");
   chk_stop_count: assert property (@(posedge mclk) disable iff (!rst_n)
      s_stop_edge ##0 (!do_reset && !do_load && !up_step && !dn_step)
      |=> $stable(r.cnt))
      else $error("stop moved the count");
   chk_cont_unf: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode == IEC_CONT && in_range) ##0 s_dn_at_min ##0 s_free_step
      |=> (r.unf && r.cnt == vmax))
      else $error("continuous down wrap not flagged");
   chk_single_silent: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode == IEC_SINGLE && !main_down) ##0 s_dn_at_min ##0 s_free_step
      |=> (!$rose(r.unf) && !r.frozen))
      else $error("single mode flagged a reverse wrap");
   chk_period_silent: assert property (@(posedge mclk) disable iff (!rst_n)
      (mode == IEC_PERIOD && !main_down) ##0 s_dn_at_min ##0 s_free_step
      |=> (!$rose(r.unf) && !r.frozen))
      else $error("periodic mode flagged a reverse wrap");
   chk_wire_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.ctrl[IEC_CTRL_QUAD] && r.s2.b == r.s2.b_n) |=> r.wire_err)
      else $error("undriven pair not flagged");
   chk_range_kept: assert property (@(posedge mclk) disable iff (!rst_n)
      (!wide && in_range && !do_reset && !do_load)
      |=> (r.cnt == {{16{r.cnt[15]}}, r.cnt[15:0]}))
      else $error("short counter left its range");
   chk_range_silent: assert property (@(posedge mclk) disable iff (!rst_n)
      (!in_range) ##0 s_free_step
      |=> (!$rose(r.ovf) && !$rose(r.unf)))
      else $error("out of range wrap was flagged");
   chk_index_home: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.ctrl[IEC_CTRL_IDXEN] && !level_rst && r.s2.n && !r.n_d
       && !r.rst_d && !(module_stop && !r.stop_d)) |=> r.home)
      else $error("index pulse did not reset");

endmodule

// file: src/iec_pkg.sv
package iec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus map (byte addresses)
   localparam logic [7:0] IEC_OFS_CTRL   = 8'h00;
   localparam logic [7:0] IEC_OFS_SWCTL  = 8'h04;
   localparam logic [7:0] IEC_OFS_LOAD   = 8'h08;
   localparam logic [7:0] IEC_OFS_COUNT  = 8'h0C;
   localparam logic [7:0] IEC_OFS_STATUS = 8'h10;

   // Control register fields
   localparam int IEC_CTRL_WIDE  = 0;
   localparam int IEC_CTRL_MODE  = 1;
   localparam int IEC_CTRL_DOWN  = 3;
   localparam int IEC_CTRL_LEVEL = 4;
   localparam int IEC_CTRL_RSRC  = 5;
   localparam int IEC_CTRL_IDXEN = 7;
   localparam int IEC_CTRL_QUAD  = 8;
   localparam logic [31:0] IEC_CTRL_RST = 32'h0000_0000;

   // Software control fields
   localparam int IEC_SW_HOLD  = 0;
   localparam int IEC_SW_RESET = 1;
   localparam int IEC_SW_LOAD  = 2;

   // Status fields
   localparam int IEC_ST_DIR   = 0;
   localparam int IEC_ST_HOME  = 1;
   localparam int IEC_ST_SYNC  = 2;
   localparam int IEC_ST_OVF   = 3;
   localparam int IEC_ST_UNF   = 4;
   localparam int IEC_ST_WIRE  = 7;

   // Range limits
   localparam logic [31:0] IEC_MAX32 = 32'h7FFF_FFFF;
   localparam logic [31:0] IEC_MIN32 = 32'h8000_0000;
   localparam logic [31:0] IEC_MAX16 = 32'h0000_7FFF;
   localparam logic [31:0] IEC_MIN16 = 32'hFFFF_8000;
   localparam logic [31:0] IEC_ZERO  = 32'h0000_0000;

   // Counting modes and reset sources
   typedef enum logic [1:0] {
      IEC_CONT   = 2'h0,
      IEC_SINGLE = 2'h1,
      IEC_PERIOD = 2'h2
   } iec_mode_t;

   typedef enum logic [1:0] {
      IEC_RV_ZERO = 2'h0,
      IEC_RV_MIN  = 2'h1,
      IEC_RV_MAX  = 2'h2,
      IEC_RV_LOAD = 2'h3
   } iec_rsrc_t;

   // Encoder pair levels, true and inverted lines
   typedef struct packed {
      logic a;
      logic a_n;
      logic b;
      logic b_n;
      logic n;
      logic n_n;
   } iec_enc_t;

   // Bus slave state
   typedef enum logic [1:0] {
      IEC_BUS_IDLE  = 2'b01,
      IEC_BUS_WRITE = 2'b10
   } iec_bus_t;

endpackage

// file: test/iec_enc_model.sv
`timescale 1ns/1ps
module iec_enc_model (
   input  wire logic     mclk,
   input  wire logic     go,
   input  wire logic     dn,
   input  wire logic     idx,
   input  wire logic     brk,
   output iec_pkg::iec_enc_t enc
);
   import iec_pkg::*;

   logic [1:0] ph = 2'h0;

   // One quarter step per go pulse; the bench spaces them out
   always @(posedge mclk) begin
      if (go) begin
         ph <= dn ? ph - 2'h1 : ph + 2'h1;
      end
   end

   // A and B stay ninety degrees apart, each with an inverted twin
   // A commanded break shows equal levels on a pair, not a driven one
   always_comb begin
      enc.a   = (ph == 2'h1) || (ph == 2'h2);
      enc.b   = ph[1];
      enc.n   = idx;
      enc.a_n = brk ? enc.a : ~enc.a;
      enc.b_n = brk ? enc.b : ~enc.b;
      enc.n_n = brk ? enc.n : ~enc.n;
   end
endmodule

// file: test/test_iec_counter.sv
`timescale 1ns/1ps
module test_iec_counter;
   import iec_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hw_hold = 1'b0;
   logic        hw_reset = 1'b0;
   logic        module_stop = 1'b0;
   logic        scan_tick = 1'b0;
   logic        go = 1'b0;
   logic        dn = 1'b0;
   logic        idx = 1'b0;
   logic        brk = 1'b0;
   logic        hwrite = 1'b0;
   logic        take = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] r;
   logic [71:0] nt;
   logic [71:0] q[$];
   logic        hready;
   logic        hresp;
   logic [7:0]  status;
   iec_enc_t    enc;
   int          bad_count = 0;
   int          comparisons = 0;
   logic [31:0] rv [4] = '{IEC_ZERO, IEC_MIN32, IEC_MAX32, 32'h1234_5678};

   always #10 mclk = ~mclk;

   iec_counter uut (.mclk(mclk), .rst_n(rst_n), .enc(enc), .hw_hold(hw_hold),
      .hw_reset(hw_reset), .module_stop(module_stop), .scan_tick(scan_tick),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hsel(1'b1), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .status(status));
   iec_enc_model partner (.mclk(mclk), .go(go), .dn(dn), .idx(idx),
      .brk(brk), .enc(enc));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [7:0] a, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL reg %h expected %h seen %h", a, e, s);
      end
   endtask

   // Read data stands in the data phase, so notes are taken in order there
   always @(posedge mclk) begin
      if (take === 1'b1) begin
         nt = q.pop_front();
         check(nt[71:64], hrdata & nt[63:32], nt[31:0] & nt[63:32]);
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic rdy;
      int i;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (hready !== 1'b1 && i < 50);
      if (hready !== 1'b1) begin
         bad_count++;
         test_done;
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, m);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      rdy;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) begin
         q.push_back({a, m, d});
         take <= 1'b1;
      end
      rdy;
      take <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0000_0000);
   endtask

   task automatic rc(input logic [31:0] e);
      bus(1'b0, IEC_OFS_COUNT, e, 32'hFFFF_FFFF);
   endtask

   task automatic rs(input logic [31:0] e, m);
      bus(1'b0, IEC_OFS_STATUS, e, m);
   endtask

   task automatic wc(input logic w, input iec_mode_t m, input logic d, l,
                     input iec_rsrc_t s, input logic x, k);
      wr(IEC_OFS_CTRL, {23'h00_0000, k, x, s, l, d, m, w});
   endtask

   // Software reset and load self-clear; give the count time to land
   task automatic sw(input logic [31:0] v);
      wr(IEC_OFS_SWCTL, v);
      cyc(3);
   endtask

   task automatic st(input logic d, input int n);
      repeat (2 * n) begin
         go <= 1'b1;
         dn <= d;
         cyc(1);
         go <= 1'b0;
         cyc(3);
      end
      cyc(6);
   endtask

   task automatic sc;
      scan_tick <= 1'b1;
      cyc(1);
      scan_tick <= 1'b0;
      cyc(1);
   endtask

   initial begin
      cyc(60000);
      bad_count++;
      test_done;
   end

   initial begin
      void'($urandom(97590));
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      rc(IEC_ZERO);
      rs(IEC_ZERO, 32'hFFFF_FFFF);
      bus(1'b0, IEC_OFS_CTRL, IEC_CTRL_RST, 32'hFFFF_FFFF);
      bus(1'b0, 8'h20, IEC_ZERO, 32'hFFFF_FFFF);
      // Continuous 16 bit; the main direction is set down on purpose
      wr(IEC_OFS_LOAD, IEC_MAX16);
      wc(1'b0, IEC_CONT, 1'b1, 1'b0, IEC_RV_LOAD, 1'b0, 1'b0);
      sw(32'h0000_0004);
      rc(IEC_MAX16);
      st(1'b0, 1);
      rc(IEC_MIN16);
      rs(32'h0000_0008, 32'h0000_0019);
      sc;
      rs(IEC_ZERO, 32'h0000_0019);
      st(1'b1, 1);
      rc(IEC_MAX16);
      rs(32'h0000_0011, 32'h0000_0019);
      sc;
      rs(32'h0000_0001, 32'h0000_0019);
      r = $urandom % 32'h0000_7FFF;
      wr(IEC_OFS_LOAD, r);
      sw(32'h0000_0004);
      st(1'b0, 1);
      rc(r + 32'h0000_0001);
      // Every reset source in periodic 32 bit
      wr(IEC_OFS_LOAD, rv[3]);
      for (int i = 0; i < 4; i++) begin
         wc(1'b1, IEC_PERIOD, 1'b0, 1'b0, iec_rsrc_t'(i[1:0]), 1'b0, 1'b0);
         sw(32'h0000_0002);
         rc(rv[i]);
         rs(32'h0000_0006, 32'h0000_0006);
      end
      wc(1'b1, IEC_PERIOD, 1'b0, 1'b0, IEC_RV_MIN, 1'b0, 1'b0);
      sw(32'h0000_0002);
      st(1'b1, 1);
      rc(IEC_MAX32);
      rs(32'h0000_0001, 32'h0000_0019);
      st(1'b0, 1);
      rs(32'h0000_0008, 32'h0000_0019);
      sc;
      // Single mode freezes after a wrap in the main direction
      wc(1'b1, IEC_SINGLE, 1'b0, 1'b0, IEC_RV_MAX, 1'b0, 1'b0);
      sw(32'h0000_0002);
      st(1'b0, 1);
      rs(32'h0000_0008, 32'h0000_0019);
      st(1'b0, 2);
      rc(IEC_MIN32);
      sc;
      wc(1'b1, IEC_SINGLE, 1'b1, 1'b0, IEC_RV_MIN, 1'b0, 1'b0);
      sw(32'h0000_0002);
      st(1'b1, 1);
      rs(32'h0000_0011, 32'h0000_0019);
      st(1'b1, 2);
      rc(IEC_MAX32);
      sc;
      // Hold against reset, edge type then level type
      wr(IEC_OFS_LOAD, 32'h0000_0005);
      wc(1'b1, IEC_CONT, 1'b0, 1'b0, IEC_RV_ZERO, 1'b0, 1'b0);
      sw(32'h0000_0004);
      hw_hold <= 1'b1;
      hw_reset <= 1'b1;
      cyc(6);
      st(1'b0, 1);
      rc(IEC_ZERO);
      hw_hold <= 1'b0;
      hw_reset <= 1'b0;
      wc(1'b1, IEC_CONT, 1'b0, 1'b1, IEC_RV_ZERO, 1'b0, 1'b0);
      sw(32'h0000_0004);
      hw_hold <= 1'b1;
      hw_reset <= 1'b1;
      cyc(6);
      hw_reset <= 1'b0;
      cyc(6);
      hw_hold <= 1'b0;
      cyc(6);
      rc(32'h0000_0005);
      hw_hold <= 1'b1;
      hw_reset <= 1'b1;
      cyc(6);
      rc(32'h0000_0005);
      hw_hold <= 1'b0;
      cyc(6);
      rc(IEC_ZERO);
      hw_reset <= 1'b0;
      // Index pulse loads the reset value
      wc(1'b1, IEC_CONT, 1'b0, 1'b0, IEC_RV_ZERO, 1'b1, 1'b0);
      sw(32'h0000_0004);
      st(1'b0, 1);
      rc(32'h0000_0006);
      idx <= 1'b1;
      cyc(4);
      idx <= 1'b0;
      cyc(6);
      rc(IEC_ZERO);
      wc(1'b1, IEC_CONT, 1'b0, 1'b0, IEC_RV_ZERO, 1'b0, 1'b1);
      brk <= 1'b1;
      cyc(6);
      rs(32'h0000_0080, 32'h0000_0080);
      brk <= 1'b0;
      cyc(6);
      rs(IEC_ZERO, 32'h0000_0080);
      // Module stop drops dir, home, scan flags and software hold but not sync or the count
      wr(IEC_OFS_LOAD, IEC_MAX32);
      wc(1'b1, IEC_CONT, 1'b0, 1'b0, IEC_RV_LOAD, 1'b0, 1'b0);
      sw(32'h0000_0004);
      st(1'b0, 1);
      sw(32'h0000_0001);
      module_stop <= 1'b1;
      cyc(6);
      rs(32'h0000_0004, 32'h0000_00FF);
      st(1'b0, 1);
      rc(32'h8000_0001);
      module_stop <= 1'b0;
      cyc(2);
      test_done;
   end
endmodule
